// >>> btg_params.svh
// register offsets, field positions and timing counts of the billing tone generator
`ifndef BTG_PARAMS_SVH
`define BTG_PARAMS_SVH

// direct register indices
`define BTG_REG_CONTROL 7'h23
`define BTG_REG_ON_LO 7'h2c
`define BTG_REG_ON_HI 7'h2d
`define BTG_REG_OFF_LO 7'h2e
`define BTG_REG_OFF_HI 7'h2f
`define BTG_REG_IND_DLO 7'h1c
`define BTG_REG_IND_DHI 7'h1d
`define BTG_REG_IND_ADDR 7'h1e
`define BTG_REG_IND_STAT 7'h1f
`define BTG_REG_IRQ_STAT 7'h13
`define BTG_REG_IRQ_EN 7'h16

// indirect register indices
`define BTG_IND_RAMP 8'h17
`define BTG_IND_AMP 8'h18
`define BTG_IND_FREQ 8'h19

// control register fields
`define BTG_CTL_STATE 0
`define BTG_CTL_ACT_EN 1
`define BTG_CTL_INACT_EN 2
`define BTG_CTL_OUT_EN 3

// interrupt status / enable fields
`define BTG_IRQ_ACT 0
`define BTG_IRQ_INACT 1

`define BTG_VOL_MAX 16'h7fff

// timing
`define BTG_CLK_HZ 125000000
`define BTG_CALC_HZ 64000
`define BTG_SAMPLE_HZ 8000
`define BTG_CALC_DIV (`BTG_CLK_HZ / `BTG_CALC_HZ)
`define BTG_CALC_PER_SAMPLE (`BTG_CALC_HZ / `BTG_SAMPLE_HZ)

`endif

// >>> btg_pkg.sv
// types of the billing tone generator
`default_nettype none
package btg_pkg;
   typedef enum logic [1:0] {
      BTG_IDLE = 2'b00,
      BTG_ACTIVE = 2'b01,
      BTG_INACTIVE = 2'b11
   } btg_cad_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [6:0] addr;
      logic [7:0] wdata;
   } btg_reg_req_t;

   typedef struct packed {
      logic [15:0] freq;
      logic [15:0] amp;
      logic [15:0] ramp;
   } btg_coef_t;
endpackage
`default_nettype wire

// >>> btg_osc.sv
// recursive sinusoid oscillator with zero start phase
`default_nettype none
module btg_osc #(
   parameter int W = 16
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic restart,
   input wire logic step,
   input wire logic [W-1:0] coeff,
   input wire logic [W-1:0] amp,
   output logic [W-1:0] sample
);
   logic signed [W-1:0] y1_q, y1_d, y2_q, y2_d;
   logic signed [2*W:0] prod;

   always_comb begin
      prod = 33'(signed'(coeff) * y1_q);
      y1_d = y1_q;
      y2_d = y2_q;
      if (restart) begin
         // zero phase: first sample 0, previous holds -amp
         y1_d = '0;
         y2_d = -signed'(amp);
      end else if (step) begin
         y1_d = W'((prod >>> (W - 2)) - 33'(y2_q));
         y2_d = y1_q;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         y1_q <= '0;
         y2_q <= '0;
      end else begin
         y1_q <= y1_d;
         y2_q <= y2_d;
      end
   end

   assign sample = y1_q;
endmodule // btg_osc
`default_nettype wire

// >>> btg_top.sv
// billing tone generator: registers, cadence timers, envelope and oscillator
`include "btg_params.svh"
`default_nettype none
//Function
// - oscillator uses the recursive sinusoid, updated at 64 kHz
// - oscillator starts at zero phase only on switch-on from zero volume, no phase register
// - active and inactive timers decrement once per 8 kHz sample
// - each timer is 16 bits split over two byte registers
// - linear envelope on every switch-on and switch-off
// - ramp-up adds ramp step to volume every 8 kHz period
// - oscillator sample times volume goes toward the DAC
// - volume rises from zero and saturates at 7fff
// - on switch-off volume falls by ramp step, stopping at zero
// - one byte control register holds state flag and three enables
// - coefficients live in indirect space via direct registers 28 to 31
// - separate interrupt events on active and inactive timer expiry if enabled
// - status bits clear on write one; irq held while any set
module btg_top (
   input wire logic clk,
   input wire logic srst,
   input wire btg_pkg::btg_reg_req_t req,
   output logic [7:0] rdata,
   output logic rvalid,
   output logic [15:0] dac_out,
   output logic dac_valid,
   output logic irq_n
);
   localparam logic [11:0] CALC_DIV = 12'(`BTG_CALC_DIV);
   localparam logic [2:0] SPS = 3'(`BTG_CALC_PER_SAMPLE - 1);

   logic [7:0] ctl_q, ctl_d;
   logic [15:0] on_t_q, on_t_d, off_t_q, off_t_d;
   logic [15:0] ind_data_q, ind_data_d;
   logic [7:0] ind_addr_q, ind_addr_d;
   logic ind_new_q, ind_new_d;
   btg_pkg::btg_coef_t coef_q, coef_d;
   logic [1:0] ist_q, ist_d, ien_q, ien_d;
   logic [7:0] rdata_q, rdata_d;
   logic rvalid_q;
   logic [11:0] div_q, div_d;
   logic [2:0] sub_q, sub_d;
   logic calc_tick, samp_tick;
   btg_pkg::btg_cad_t cad_q, cad_d;
   logic [15:0] cnt_q, cnt_d;
   logic [15:0] vol_q, vol_d;
   logic [15:0] dac_q, dac_d;
   logic dval_q;
   logic irq_n_q;
   logic restart;
   logic [15:0] osc_s;
   logic signed [31:0] mult;
   logic [16:0] vsum;
   logic ev_act, ev_inact;

   // rate dividers: 64 kHz computation and 8 kHz sample
   always_comb begin
      calc_tick = (div_q == CALC_DIV - 12'h001);
      div_d = calc_tick ? 12'h000 : div_q + 12'h001;
      samp_tick = calc_tick && (sub_q == SPS);
      sub_d = calc_tick ? sub_q + 3'h1 : sub_q;
   end

   // register file and indirect window
   always_comb begin
      ctl_d = ctl_q;
      on_t_d = on_t_q;
      off_t_d = off_t_q;
      ind_data_d = ind_data_q;
      ind_addr_d = ind_addr_q;
      ind_new_d = ind_new_q;
      coef_d = coef_q;
      ien_d = ien_q;
      rdata_d = rdata_q;
      if (req.wr) begin
         case (req.addr)
            `BTG_REG_CONTROL: ctl_d[3:1] = req.wdata[3:1];
            `BTG_REG_ON_LO: on_t_d[7:0] = req.wdata;
            `BTG_REG_ON_HI: on_t_d[15:8] = req.wdata;
            `BTG_REG_OFF_LO: off_t_d[7:0] = req.wdata;
            `BTG_REG_OFF_HI: off_t_d[15:8] = req.wdata;
            `BTG_REG_IND_DLO: begin
               ind_data_d[7:0] = req.wdata;
               ind_new_d = 1'b1;
            end
            `BTG_REG_IND_DHI: begin
               ind_data_d[15:8] = req.wdata;
               ind_new_d = 1'b1;
            end
            `BTG_REG_IRQ_EN: ien_d = req.wdata[1:0];
            `BTG_REG_IND_ADDR: begin
               // only a freshly staged word is committed, so setting up a read
               // leaves the coefficient alone
               ind_addr_d = {1'b0, req.wdata[6:0]};
               ind_new_d = 1'b0;
               if (ind_new_q) begin
                  case ({1'b0, req.wdata[6:0]})
                     `BTG_IND_RAMP: coef_d.ramp = ind_data_q;
                     `BTG_IND_AMP: coef_d.amp = ind_data_q;
                     `BTG_IND_FREQ: coef_d.freq = ind_data_q;
                     default: ;
                  endcase
               end
            end
            default: ;
         endcase
      end
      if (req.rd) begin
         case (req.addr)
            `BTG_REG_CONTROL: rdata_d = {4'h0, ctl_q[3:1], cad_q != btg_pkg::BTG_IDLE};
            `BTG_REG_ON_LO: rdata_d = on_t_q[7:0];
            `BTG_REG_ON_HI: rdata_d = on_t_q[15:8];
            `BTG_REG_OFF_LO: rdata_d = off_t_q[7:0];
            `BTG_REG_OFF_HI: rdata_d = off_t_q[15:8];
            `BTG_REG_IND_DLO: rdata_d = ind_data_q[7:0];
            `BTG_REG_IND_DHI: rdata_d = ind_data_q[15:8];
            `BTG_REG_IND_ADDR: rdata_d = ind_addr_q;
            `BTG_REG_IND_STAT: rdata_d = 8'h00;
            `BTG_REG_IRQ_STAT: rdata_d = {6'h00, ist_q};
            `BTG_REG_IRQ_EN: rdata_d = {6'h00, ien_q};
            default: rdata_d = 8'h00;
         endcase
      end
      // a write to the status register fetches the word at the stored index
      if (req.wr && req.addr == `BTG_REG_IND_STAT) begin
         case (ind_addr_q)
            `BTG_IND_RAMP: ind_data_d = coef_q.ramp;
            `BTG_IND_AMP: ind_data_d = coef_q.amp;
            `BTG_IND_FREQ: ind_data_d = coef_q.freq;
            default: ind_data_d = 16'h0000;
         endcase
      end
   end

   // cadence: active time, then inactive time, while the output enable holds
   always_comb begin
      cad_d = cad_q;
      cnt_d = cnt_q;
      ev_act = 1'b0;
      ev_inact = 1'b0;
      restart = 1'b0;
      if (!ctl_q[`BTG_CTL_OUT_EN]) begin
         cad_d = btg_pkg::BTG_IDLE;
      end else begin
         case (cad_q)
            btg_pkg::BTG_IDLE: begin
               cad_d = btg_pkg::BTG_ACTIVE;
               cnt_d = on_t_q;
               restart = (vol_q == 16'h0000);
            end
            btg_pkg::BTG_ACTIVE: if (samp_tick && ctl_q[`BTG_CTL_ACT_EN]) begin
               if (cnt_q == 16'h0000) begin
                  ev_act = 1'b1;
                  cad_d = btg_pkg::BTG_INACTIVE;
                  cnt_d = off_t_q;
               end else begin
                  cnt_d = cnt_q - 16'h0001;
               end
            end
            btg_pkg::BTG_INACTIVE: if (samp_tick && ctl_q[`BTG_CTL_INACT_EN]) begin
               if (cnt_q == 16'h0000) begin
                  ev_inact = 1'b1;
                  cad_d = btg_pkg::BTG_ACTIVE;
                  cnt_d = on_t_q;
               end else begin
                  cnt_d = cnt_q - 16'h0001;
               end
            end
            default: cad_d = btg_pkg::BTG_IDLE;
         endcase
      end
   end

   // volume envelope at 8 kHz
   always_comb begin
      vol_d = vol_q;
      vsum = 17'(vol_q) + 17'(coef_q.ramp);
      if (samp_tick) begin
         if (cad_q == btg_pkg::BTG_ACTIVE) begin
            vol_d = (vsum > 17'(`BTG_VOL_MAX)) ? `BTG_VOL_MAX : vsum[15:0];
         end else begin
            vol_d = (vol_q > coef_q.ramp) ? vol_q - coef_q.ramp : 16'h0000;
         end
      end
   end

   btg_osc #(.W(16)) u_osc (
      .clk(clk),
      .srst(srst),
      .restart(restart),
      .step(calc_tick),
      .coeff(coef_q.freq),
      .amp(coef_q.amp),
      .sample(osc_s)
   );

   // output scaling and interrupts
   always_comb begin
      mult = signed'(osc_s) * signed'({1'b0, vol_q[14:0]});
      dac_d = dac_q;
      if (calc_tick) begin
         dac_d = mult[30:15];
      end
      ist_d = ist_q;
      if (req.wr && req.addr == `BTG_REG_IRQ_STAT) begin
         ist_d = ist_q & ~req.wdata[1:0];
      end
      if (ev_act && ien_q[`BTG_IRQ_ACT]) begin
         ist_d[`BTG_IRQ_ACT] = 1'b1;
      end
      if (ev_inact && ien_q[`BTG_IRQ_INACT]) begin
         ist_d[`BTG_IRQ_INACT] = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         ctl_q <= 8'h00;
         on_t_q <= 16'h0000;
         off_t_q <= 16'h0000;
         ind_data_q <= 16'h0000;
         ind_addr_q <= 8'h00;
         ind_new_q <= 1'b0;
         coef_q <= '0;
         ien_q <= 2'h0;
         ist_q <= 2'h0;
         rdata_q <= 8'h00;
         rvalid_q <= 1'b0;
         div_q <= 12'h000;
         sub_q <= 3'h0;
         cad_q <= btg_pkg::BTG_IDLE;
         cnt_q <= 16'h0000;
         vol_q <= 16'h0000;
         dac_q <= 16'h0000;
         dval_q <= 1'b0;
         irq_n_q <= 1'b1;
      end else begin
         ctl_q <= ctl_d;
         on_t_q <= on_t_d;
         off_t_q <= off_t_d;
         ind_data_q <= ind_data_d;
         ind_addr_q <= ind_addr_d;
         ind_new_q <= ind_new_d;
         coef_q <= coef_d;
         ien_q <= ien_d;
         ist_q <= ist_d;
         rdata_q <= rdata_d;
         rvalid_q <= req.rd;
         div_q <= div_d;
         sub_q <= sub_d;
         cad_q <= cad_d;
         cnt_q <= cnt_d;
         vol_q <= vol_d;
         dac_q <= dac_d;
         dval_q <= calc_tick;
         irq_n_q <= ~(|ist_d);
      end
   end

   assign rdata = rdata_q;
   assign rvalid = rvalid_q;
   assign dac_out = dac_q;
   assign dac_valid = dval_q;
   assign irq_n = irq_n_q;

   property p_vol_cap;
      @(posedge clk) disable iff (srst) vol_q <= `BTG_VOL_MAX;
   endproperty
   a_vol_cap: assert property (p_vol_cap) else $error("volume above ceiling");

   property p_off_fall;
      @(posedge clk) disable iff (srst)
         (samp_tick && cad_q != btg_pkg::BTG_ACTIVE && vol_q != 16'h0000
         && coef_q.ramp != 16'h0000) |=> vol_q < $past(vol_q);
   endproperty
   a_off_fall: assert property (p_off_fall) else $error("volume not falling");

   property p_vol_slow;
      @(posedge clk) disable iff (srst) !samp_tick |=> $stable(vol_q);
   endproperty
   a_vol_slow: assert property (p_vol_slow) else $error("volume moved off sample");

   property p_cnt_slow;
      @(posedge clk) disable iff (srst)
         (!samp_tick && cad_q == $past(cad_q) && cad_q != btg_pkg::BTG_IDLE) |=> $stable(cnt_q);
   endproperty
   a_cnt_slow: assert property (p_cnt_slow) else $error("timer moved off sample");

   property p_irq_act;
      @(posedge clk) disable iff (srst) (ev_act && ien_q[0]) |=> ist_q[0] && !irq_n;
   endproperty
   a_irq_act: assert property (p_irq_act) else $error("active expiry lost");

   property p_irq_dis;
      @(posedge clk) disable iff (srst) (ev_inact && !ien_q[1] && !ist_q[1]
         && !(req.wr && req.addr == `BTG_REG_IRQ_STAT)) |=> !ist_q[1];
   endproperty
   a_irq_dis: assert property (p_irq_dis) else $error("disabled event latched");

   property p_irq_hold;
      @(posedge clk) disable iff (srst) (ist_q != 2'h0 && !req.wr) |=> ist_q != 2'h0 && !irq_n;
   endproperty
   a_irq_hold: assert property (p_irq_hold) else $error("status dropped");

   property p_restart;
      @(posedge clk) disable iff (srst) restart |=> osc_s == 16'h0000;
   endproperty
   a_restart: assert property (p_restart) else $error("phase not zero");

   property p_ctl_read;
      @(posedge clk) disable iff (srst)
         (req.rd && req.addr == `BTG_REG_CONTROL) |=> rvalid && rdata[7:4] == 4'h0;
   endproperty
   a_ctl_read: assert property (p_ctl_read) else $error("bad control read");

   c_ramp_top: cover property (@(posedge clk) vol_q == `BTG_VOL_MAX);
   c_act_exp: cover property (@(posedge clk) ev_act);
   c_inact_exp: cover property (@(posedge clk) ev_inact);
   c_irq: cover property (@(posedge clk) !irq_n);
endmodule // btg_top
`default_nettype wire

// >>> btg_top_tb.sv
// self-checking testbench of the billing tone generator
`include "btg_params.svh"
`default_nettype none
`define BTG_TB_CHK(got, exp) \
   begin \
      n_checks++; \
      if ((got) !== (exp)) begin \
         failures++; \
         $display("[FAIL] t=%0t got %h exp %h", $time, (got), (exp)); \
      end \
   end
module btg_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk;
   logic srst;
   btg_pkg::btg_reg_req_t req;
   logic [7:0] rdata;
   logic rvalid;
   logic [15:0] dac_out;
   logic dac_valid;
   logic irq_n;
   int failures;
   int n_checks;
   logic [7:0] b;
   logic [15:0] w;

   btg_top dut_u (
      .clk(clk),
      .srst(srst),
      .req(req),
      .rdata(rdata),
      .rvalid(rvalid),
      .dac_out(dac_out),
      .dac_valid(dac_valid),
      .irq_n(irq_n)
   );

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // every access task starts and ends on a falling edge, with one idle cycle after
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      req.wr = 1'b1;
      req.addr = a;
      req.wdata = d;
      @(negedge clk);
      req.wr = 1'b0;
      @(negedge clk);
   endtask

   task automatic rd(input logic [6:0] a, output logic [7:0] d);
      req.rd = 1'b1;
      req.addr = a;
      @(negedge clk);
      req.rd = 1'b0;
      `BTG_TB_CHK(rvalid, 1'b1);
      d = rdata;
      @(negedge clk);
   endtask

   task automatic ind_wr(input logic [7:0] idx, input logic [15:0] v);
      wr(`BTG_REG_IND_DLO, v[7:0]);
      wr(`BTG_REG_IND_DHI, v[15:8]);
      wr(`BTG_REG_IND_ADDR, idx);
   endtask

   task automatic ind_rd(input logic [7:0] idx, output logic [15:0] v);
      wr(`BTG_REG_IND_ADDR, idx);
      wr(`BTG_REG_IND_STAT, 8'h00);
      rd(`BTG_REG_IND_DLO, v[7:0]);
      rd(`BTG_REG_IND_DHI, v[15:8]);
   endtask

   task automatic wait_dac(input int n);
      repeat (n) @(posedge dac_valid);
      @(negedge clk);
   endtask

   task automatic wait_irq();
      for (int i = 0; i < 40000 && irq_n !== 1'b0; i++) @(negedge clk);
   endtask

   task automatic t_reset();
      `BTG_TB_CHK({rvalid, dac_valid, irq_n, rdata, dac_out}, {3'b001, 24'h0});
      rd(`BTG_REG_CONTROL, b);
      `BTG_TB_CHK(b, 8'h00);
      wr(7'h7f, 8'hff);
      rd(7'h7f, b);
      `BTG_TB_CHK(b, 8'h00);
   endtask

   task automatic t_regs();
      logic [6:0] a[4] = '{`BTG_REG_ON_LO, `BTG_REG_ON_HI, `BTG_REG_OFF_LO, `BTG_REG_OFF_HI};
      for (int i = 0; i < 4; i++) wr(a[i], 8'ha5 ^ 8'(i * 17));
      for (int i = 0; i < 4; i++) begin
         rd(a[i], b);
         `BTG_TB_CHK(b, 8'ha5 ^ 8'(i * 17));
      end
      wr(`BTG_REG_CONTROL, 8'h07);
      rd(`BTG_REG_CONTROL, b);
      `BTG_TB_CHK(b, 8'h06);
      wr(`BTG_REG_CONTROL, 8'h00);
   endtask

   task automatic t_ind();
      logic [7:0] idx[3] = '{`BTG_IND_RAMP, `BTG_IND_AMP, `BTG_IND_FREQ};
      for (int i = 0; i < 3; i++) ind_wr(idx[i], 16'hc35a + 16'(i * 16'h1111));
      for (int i = 0; i < 3; i++) begin
         ind_rd(idx[i], w);
         `BTG_TB_CHK(w, 16'hc35a + 16'(i * 16'h1111));
      end
      rd(`BTG_REG_IND_STAT, b);
      `BTG_TB_CHK(b, 8'h00);
   endtask

   task automatic t_tone();
      int n;
      logic nz;
      ind_wr(`BTG_IND_AMP, 16'h4000);
      ind_wr(`BTG_IND_RAMP, 16'h4000);
      // 12 kHz tone: cos(2*pi*12000/64000) * 32768
      ind_wr(`BTG_IND_FREQ, 16'h30fc);
      wr(`BTG_REG_CONTROL, 8'h08);
      rd(`BTG_REG_CONTROL, b);
      `BTG_TB_CHK(b, 8'h09);
      // count falling edges so the pulse is never read on its launching edge
      @(posedge dac_valid);
      @(negedge clk);
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (dac_valid !== 1'b1 && n < 4000);
      `BTG_TB_CHK(n, `BTG_CALC_DIV);
      nz = 1'b0;
      for (int i = 0; i < 10; i++) begin
         wait_dac(1);
         nz = nz | (dac_out !== 16'h0000);
      end
      `BTG_TB_CHK(nz, 1'b1);
      wr(`BTG_REG_CONTROL, 8'h00);
      // one 8 kHz tick takes the volume from 4000 down to zero
      wait_dac(18);
      for (int i = 0; i < 2; i++) begin
         wait_dac(1);
         `BTG_TB_CHK(dac_out, 16'h0000);
      end
      rd(`BTG_REG_CONTROL, b);
      `BTG_TB_CHK(b, 8'h00);
   endtask

   task automatic t_timer();
      realtime t1;
      wr(`BTG_REG_IRQ_EN, 8'h03);
      rd(`BTG_REG_IRQ_EN, b);
      `BTG_TB_CHK(b, 8'h03);
      for (int i = 0; i < 4; i++) wr(7'(`BTG_REG_ON_LO + i), 8'h00);
      wr(`BTG_REG_CONTROL, 8'h0e);
      wait_irq();
      t1 = $realtime;
      rd(`BTG_REG_IRQ_STAT, b);
      `BTG_TB_CHK(b, 8'h01);
      wr(`BTG_REG_IRQ_STAT, 8'h00);
      rd(`BTG_REG_IRQ_STAT, b);
      `BTG_TB_CHK(b, 8'h01);
      `BTG_TB_CHK(irq_n, 1'b0);
      wr(`BTG_REG_IRQ_STAT, 8'h01);
      rd(`BTG_REG_IRQ_STAT, b);
      `BTG_TB_CHK(b, 8'h00);
      `BTG_TB_CHK(irq_n, 1'b1);
      wait_irq();
      // timer value zero expires after one 8 kHz sample tick
      `BTG_TB_CHK(int'(($realtime - t1) / 8.0), 8 * `BTG_CALC_DIV);
      rd(`BTG_REG_IRQ_STAT, b);
      `BTG_TB_CHK(b, 8'h02);
      wr(`BTG_REG_CONTROL, 8'h00);
      wr(`BTG_REG_IRQ_STAT, 8'h03);
      rd(`BTG_REG_IRQ_STAT, b);
      `BTG_TB_CHK(b, 8'h00);
   endtask

   // the scenarios need about 94000 cycles at most
   initial begin
      repeat (100000) @(posedge clk);
      failures++;
      close_out();
   end

   initial begin
      failures = 0;
      n_checks = 0;
      req = '0;
      srst = 1'b1;
      repeat (5) @(negedge clk);
      srst = 1'b0;
      @(negedge clk);
      t_reset();
      t_regs();
      t_ind();
      t_tone();
      t_timer();
      close_out();
   end
endmodule // btg_top_tb
`default_nettype wire
